// ### core/omms_pkg.sv
// Constants and types for the optical module management slave
package omms_pkg;
   // Two-wire slave addresses (7-bit form)
   localparam logic [6:0] ADDR_ID = 7'h50;
   localparam logic [6:0] ADDR_DIAG = 7'h51;
   // APB register offsets
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_STATUS = 12'h004;
   localparam logic [11:0] REG_MASK = 12'h008;
   localparam logic [11:0] REG_MEMWR = 12'h00c;
   localparam logic [11:0] REG_STATE = 12'h010;
   localparam logic [11:0] REG_MON_BASE = 12'h040;
   localparam logic [11:0] REG_MON_END = 12'h054;
   localparam logic [11:0] REG_LIM_BASE = 12'h080;
   localparam logic [11:0] REG_LIM_END = 12'h0d0;
   // Control bits
   localparam int CTRL_WP_ID = 0;
   localparam int CTRL_SOFT_DIS = 1;
   localparam int CTRL_FAULT_FORCE = 2;
   localparam int CTRL_W = 3;
   localparam logic [2:0] CTRL_RST = 3'h1;
   // Memory write register fields
   localparam int MW_SEL = 16;
   // Event bits of status and mask
   localparam int ST_ALARM = 0;
   localparam int ST_WARN = 1;
   localparam int ST_HOSTWR = 2;
   localparam int ST_FAULT = 3;
   localparam int ST_LOS = 4;
   localparam int NEV = 5;
   // Monitored parameters and limit slots
   localparam int NPARAM = 5;
   localparam int NLIM = 4;
   localparam int LIM_HA = 0;
   localparam int LIM_LA = 1;
   localparam int LIM_HW = 2;
   localparam int LIM_LW = 3;
   localparam int NFLAG = 2 * NPARAM;
   // Diagnostic area byte map
   localparam logic [7:0] DG_MON_LO = 8'h60;
   localparam logic [7:0] DG_MON_HI = 8'h69;
   localparam logic [7:0] DG_STAT = 8'h6e;
   localparam logic [7:0] DG_ALM0 = 8'h70;
   localparam logic [7:0] DG_ALM1 = 8'h71;
   localparam logic [7:0] DG_WRN0 = 8'h74;
   localparam logic [7:0] DG_WRN1 = 8'h75;
   localparam logic [7:0] DG_LIVE_LO = 8'h60;
   localparam logic [7:0] DG_LIVE_HI = 8'h7f;
   // Calibration type byte in identification memory
   localparam logic [7:0] ID_DIAG_TYPE = 8'h5c;
   localparam logic [7:0] CAL_INT_MASK = 8'h20;
   // Synchroniser lanes: scl, sda, tx disable, signal ok, fault
   localparam int NSYNC = 5;
   localparam logic [4:0] SYNC_INIT = 5'h07;
   // Transmitter shutdown bound
   localparam int CLK_NS = 50;
   localparam int TXDIS_MAX_NS = 10000;
   localparam int TXDIS_CYC = TXDIS_MAX_NS / CLK_NS;
   // Two-wire engine states
   typedef enum logic [3:0] {
      S_IDLE, S_DEV, S_DEV_ACK, S_WADR, S_WADR_ACK,
      S_WDAT, S_WDAT_ACK, S_RDAT, S_RACK
   } omms_state_e;
endpackage

// ### core/omms_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module omms_sync
   import omms_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET,
   input wire logic [NSYNC-1:0] d,
   output logic [NSYNC-1:0] q
);
   logic [NSYNC-1:0] s1_r;
   logic [NSYNC-1:0] s2_r;
   logic [NSYNC-1:0] s3_r;
   logic [NSYNC-1:0] q_nxt;

   // Accept a level once stages two and three agree
   assign q_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & q);

   // Shift chain
   always_ff @(posedge CLK) begin
      if (RESET) begin
         s1_r <= SYNC_INIT;
         s2_r <= SYNC_INIT;
         s3_r <= SYNC_INIT;
         q <= SYNC_INIT;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q <= q_nxt;
      end
   end
endmodule

// ### core/omms_mem.sv
// Byte memory with one write port and a registered read port
`timescale 1ns/1ps
module omms_mem
   import omms_pkg::*;
(
   input wire logic CLK,
   input wire logic we,
   input wire logic [7:0] wadr,
   input wire logic [7:0] wdat,
   input wire logic [7:0] radr,
   output logic [7:0] rdat
);
   logic [7:0] mem [256];

   // Write and registered read
   always_ff @(posedge CLK) begin
      if (we) begin
         mem[wadr] <= wdat;
      end
      rdat <= mem[radr];
   end
endmodule

// ### core/omms_top.sv
// Management slave of a pluggable optical module
//
// Behaviour
// - A 256-byte identification memory answers at address 1010000X.
// - Diagnostic data answers at address 1010001X, ID map unchanged.
// - Bits are taken on rising clock; writes skip protected areas.
// - Outgoing bits are launched on the falling serial clock edge.
// - Data is two-way; start and stop (data moves, clock high) seen.
// - Both memories hold bytes, reached singly or in sequential runs.
// - Live temperature, bias, tx power, rx power and supply readable.
// - Alarm and warning flags set when a value leaves its range.
// - Values are reported internally calibrated by default.
// - Signal-loss output is 0 with signal present, 1 without.
// - Shutdown input stops transmission within 10 us.
// - Transmitter is off while shutdown input is high, on when low and soft disable is clear.
// - Fault output is high on any laser fault or with fault force set, low otherwise.
// - Presence pin is held permanently low.
`timescale 1ns/1ps
module omms_top
   import omms_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic IRQ,
   input wire logic SCL,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE_N,
   input wire logic TX_DISABLE,
   input wire logic RX_SIGNAL_OK,
   input wire logic LASER_FAULT,
   output logic TX_ON,
   output logic TX_FAULT,
   output logic RX_SIGNAL_LOST,
   output logic PRESENT_N
);
   localparam int TXDIS_BOUND = TXDIS_CYC;

   ////////////////////////////////////////////////////////////////////////
   // Functions
   function automatic logic out_high(input logic [15:0] v,
                                     input logic [15:0] lim);
      return v > lim;
   endfunction

   function automatic logic out_low(input logic [15:0] v,
                                    input logic [15:0] lim);
      return v < lim;
   endfunction

   function automatic logic [2:0] word_idx(input logic [11:0] a,
                                           input logic [11:0] base);
      logic [11:0] d;
      d = a - base;
      return d[4:2];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [NSYNC-1:0] sync_q;
   logic scl_s, sda_s, txdis_s, sigok_s, fault_s;
   logic scl_q_r, sda_q_r;
   logic scl_rise, scl_fall, start_c, stop_c;
   omms_state_e state_r, state_nxt;
   logic [2:0] cnt_r, cnt_nxt;
   logic [7:0] sh_r, sh_nxt, txb_r, txb_nxt;
   logic [7:0] wadr_r, wadr_nxt, dev_r, dev_nxt;
   logic sel_r, sel_nxt, rw_r, rw_nxt, ack_ok_r, ack_ok_nxt;
   logic oe_n_nxt;
   logic [7:0] byte_in;
   logic pw_pend_r, pw_sel_r, pw_cap;
   logic [7:0] pw_adr_r, pw_dat_r;
   logic [CTRL_W-1:0] ctrl_r;
   logic [NEV-1:0] mask_r, st_r, st_nxt, ev;
   logic [15:0] mon_r [NPARAM];
   logic [15:0] lim_r [NPARAM][NLIM];
   logic [NFLAG-1:0] alm_r, wrn_r, alm_c, wrn_c;
   logic los_q_r, fault_q_r;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   omms_sync u_sync (
      .CLK(CLK),
      .RESET(RESET),
      .d({LASER_FAULT, RX_SIGNAL_OK, TX_DISABLE, SDA_IN, SCL}),
      .q(sync_q)
   );
   assign {fault_s, sigok_s, txdis_s, sda_s, scl_s} = sync_q;

   assign scl_rise = scl_s & ~scl_q_r;
   assign scl_fall = ~scl_s & scl_q_r;
   assign start_c = scl_s & scl_q_r & sda_q_r & ~sda_s;
   assign stop_c = scl_s & scl_q_r & ~sda_q_r & sda_s;
   assign byte_in = {sh_r[6:0], sda_s};

   ////////////////////////////////////////////////////////////////////////
   // APB decode
   logic apb_setup, apb_acc, apb_wr, aligned;
   logic is_mon, is_lim, mapped;
   logic [2:0] mon_i, lim_i;
   logic [1:0] lim_k;
   logic [31:0] apb_rd;
   logic mw_wr, rd_status;
   assign apb_setup = PSEL & ~PENABLE;
   assign apb_acc = PSEL & PENABLE & PREADY;
   assign apb_wr = apb_acc & PWRITE & mapped;
   assign aligned = PADDR[1:0] == 2'h0;
   assign is_mon = PADDR >= REG_MON_BASE && PADDR < REG_MON_END;
   assign is_lim = PADDR >= REG_LIM_BASE && PADDR < REG_LIM_END;
   assign mon_i = word_idx(PADDR, REG_MON_BASE);
   assign lim_i = 3'((PADDR - REG_LIM_BASE) >> 4);
   assign lim_k = PADDR[3:2];
   assign mapped = aligned & (is_mon | is_lim | PADDR == REG_CTRL
      | PADDR == REG_STATUS | PADDR == REG_MASK
      | PADDR == REG_MEMWR | PADDR == REG_STATE);
   assign mw_wr = apb_wr & (PADDR == REG_MEMWR);
   assign rd_status = apb_acc & ~PWRITE & (PADDR == REG_STATUS);
   assign apb_rd = !mapped ? 32'h0 :
      is_mon ? {16'h0, mon_r[mon_i]} :
      is_lim ? {16'h0, lim_r[lim_i][lim_k]} :
      PADDR == REG_CTRL ? {29'h0, ctrl_r} :
      PADDR == REG_STATUS ? {27'h0, st_r} :
      PADDR == REG_MASK ? {27'h0, mask_r} :
      PADDR == REG_STATE ? {23'h0, state_r, TX_ON, TX_FAULT,
                            RX_SIGNAL_LOST, txdis_s, pw_pend_r} :
      32'h0;

   // Zero-wait answer: ready and data registered in setup
   always_ff @(posedge CLK) begin
      if (RESET) begin
         PREADY <= 1'b0;
         PRDATA <= 32'h0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= apb_setup;
         PRDATA <= apb_setup ? apb_rd : PRDATA;
         PSLVERR <= apb_setup & ~mapped;
      end
   end

   // Control and mask registers
   always_ff @(posedge CLK) begin
      if (RESET) begin
         ctrl_r <= CTRL_RST;
         mask_r <= '0;
      end else if (apb_wr) begin
         if (PADDR == REG_CTRL) ctrl_r <= PWDATA[CTRL_W-1:0];
         if (PADDR == REG_MASK) mask_r <= PWDATA[NEV-1:0];
      end
   end

   // live values and limits written by the monitor firmware
   always_ff @(posedge CLK) begin
      if (RESET) begin
         for (int i = 0; i < NPARAM; i++) begin
            mon_r[i] <= 16'h0;
            for (int k = 0; k < NLIM; k++) lim_r[i][k] <= 16'h0;
         end
      end else if (apb_wr & is_mon) begin
         mon_r[mon_i] <= PWDATA[15:0];
      end else if (apb_wr & is_lim) begin
         lim_r[lim_i][lim_k] <= PWDATA[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // range checks, high and low flag per parameter
   always_comb begin
      for (int i = 0; i < NPARAM; i++) begin
         alm_c[NFLAG-1-2*i] = out_high(mon_r[i], lim_r[i][LIM_HA]);
         alm_c[NFLAG-2-2*i] = out_low(mon_r[i], lim_r[i][LIM_LA]);
         wrn_c[NFLAG-1-2*i] = out_high(mon_r[i], lim_r[i][LIM_HW]);
         wrn_c[NFLAG-2-2*i] = out_low(mon_r[i], lim_r[i][LIM_LW]);
      end
   end

   // Events; set wins over read-clear
   assign ev[ST_ALARM] = |(alm_c & ~alm_r);
   assign ev[ST_WARN] = |(wrn_c & ~wrn_r);
   assign ev[ST_HOSTWR] = pw_cap;
   assign ev[ST_FAULT] = fault_s & ~fault_q_r;
   assign ev[ST_LOS] = ~sigok_s & ~los_q_r;
   assign st_nxt = (rd_status ? '0 : st_r) | ev;

   // Flags, status and interrupt
   always_ff @(posedge CLK) begin
      if (RESET) begin
         alm_r <= '0;
         wrn_r <= '0;
         st_r <= '0;
         IRQ <= 1'b0;
         fault_q_r <= 1'b0;
         los_q_r <= 1'b1;
      end else begin
         alm_r <= alm_c;
         wrn_r <= wrn_c;
         st_r <= st_nxt;
         IRQ <= |(st_nxt & mask_r);
         fault_q_r <= fault_s;
         los_q_r <= ~sigok_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Module status pins
   always_ff @(posedge CLK) begin
      if (RESET) begin
         TX_ON <= 1'b0;
         TX_FAULT <= 1'b0;
         RX_SIGNAL_LOST <= 1'b1;
         PRESENT_N <= 1'b0;
         SDA_OUT <= 1'b0;
      end else begin
         // on only with input low and no soft disable
         TX_ON <= ~txdis_s & ~ctrl_r[CTRL_SOFT_DIS];
         TX_FAULT <= fault_s | ctrl_r[CTRL_FAULT_FORCE];
         // loss flag inverse of signal present
         RX_SIGNAL_LOST <= ~sigok_s;
         PRESENT_N <= 1'b0;
         SDA_OUT <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Memories and read byte selection
   logic we_any, we_sel, apb_mw_sel;
   logic [7:0] we_adr, we_dat, id_q, dg_q, rd_byte, live_byte;
   logic [15:0] mon_word;
   logic [7:0] mon_off, st_byte;
   logic in_live, pw_ok;
   assign apb_mw_sel = PWDATA[MW_SEL];
   assign we_any = mw_wr | pw_pend_r;
   assign we_sel = mw_wr ? apb_mw_sel : pw_sel_r;
   assign we_adr = mw_wr ? PWDATA[15:8] : pw_adr_r;
   assign we_dat = mw_wr ? PWDATA[7:0] : pw_dat_r;

   omms_mem u_id (
      .CLK(CLK),
      .we(we_any & ~we_sel),
      .wadr(we_adr),
      .wdat(we_dat),
      .radr(wadr_r),
      .rdat(id_q)
   );
   omms_mem u_dg (
      .CLK(CLK),
      .we(we_any & we_sel),
      .wadr(we_adr),
      .wdat(we_dat),
      .radr(wadr_r),
      .rdat(dg_q)
   );

   assign mon_off = wadr_r - DG_MON_LO;
   assign mon_word = mon_r[mon_off[3:1]];
   assign st_byte = {txdis_s, ctrl_r[CTRL_SOFT_DIS], 3'h0, TX_FAULT,
                     RX_SIGNAL_LOST, 1'b0};
   assign live_byte =
      (wadr_r >= DG_MON_LO && wadr_r <= DG_MON_HI) ?
         (wadr_r[0] ? mon_word[7:0] : mon_word[15:8]) :
      wadr_r == DG_STAT ? st_byte :
      wadr_r == DG_ALM0 ? alm_r[NFLAG-1:2] :
      wadr_r == DG_ALM1 ? {alm_r[1:0], 6'h0} :
      wadr_r == DG_WRN0 ? wrn_r[NFLAG-1:2] :
      wadr_r == DG_WRN1 ? {wrn_r[1:0], 6'h0} : dg_q;
   assign in_live = wadr_r >= DG_LIVE_LO && wadr_r <= DG_LIVE_HI;
   assign rd_byte = sel_r ? (in_live ? live_byte : dg_q) :
      (wadr_r == ID_DIAG_TYPE ? (id_q | CAL_INT_MASK) : id_q);
   assign pw_ok = sel_r ? ~in_live : ~ctrl_r[CTRL_WP_ID];

   ////////////////////////////////////////////////////////////////////////
   // Two-wire engine
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      sh_nxt = sh_r;
      txb_nxt = txb_r;
      wadr_nxt = wadr_r;
      dev_nxt = dev_r;
      sel_nxt = sel_r;
      rw_nxt = rw_r;
      ack_ok_nxt = ack_ok_r;
      oe_n_nxt = SDA_OE_N;
      pw_cap = 1'b0;
      if (start_c) begin
         state_nxt = S_DEV;
         cnt_nxt = 3'h0;
         oe_n_nxt = 1'b1;
      end else if (stop_c) begin
         state_nxt = S_IDLE;
         oe_n_nxt = 1'b1;
      end else if (scl_rise) begin
         unique case (state_r)
            // bits taken on the rising edge
            S_DEV, S_WADR, S_WDAT: begin
               sh_nxt = byte_in;
               cnt_nxt = cnt_r + 3'h1;
               if (cnt_r == 3'h7 && state_r == S_DEV) begin
                  dev_nxt = byte_in;
                  sel_nxt = byte_in[1];
                  rw_nxt = byte_in[0];
                  state_nxt = (byte_in[7:1] == ADDR_ID
                     || byte_in[7:1] == ADDR_DIAG) ? S_DEV_ACK : S_IDLE;
               end else if (cnt_r == 3'h7 && state_r == S_WADR) begin
                  wadr_nxt = byte_in;
                  state_nxt = S_WADR_ACK;
               end else if (cnt_r == 3'h7) begin
                  pw_cap = pw_ok;
                  // step and wrap after each byte
                  wadr_nxt = wadr_r + 8'h1;
                  state_nxt = S_WDAT_ACK;
               end
            end
            S_RACK: ack_ok_nxt = ~sda_s;
            default: ;
         endcase
      end else if (scl_fall) begin
         unique case (state_r)
            S_DEV_ACK, S_WADR_ACK, S_WDAT_ACK: begin
               cnt_nxt = 3'h0;
               if (SDA_OE_N) begin
                  oe_n_nxt = 1'b0;
               end else if (state_r == S_DEV_ACK && rw_r) begin
                  txb_nxt = rd_byte;
                  oe_n_nxt = rd_byte[7];
                  wadr_nxt = wadr_r + 8'h1;
                  state_nxt = S_RDAT;
               end else begin
                  oe_n_nxt = 1'b1;
                  state_nxt = state_r == S_DEV_ACK ? S_WADR : S_WDAT;
               end
            end
            // bits launched on the falling edge
            S_RDAT: begin
               if (cnt_r == 3'h7) begin
                  oe_n_nxt = 1'b1;
                  state_nxt = S_RACK;
               end else begin
                  txb_nxt = {txb_r[6:0], 1'b0};
                  oe_n_nxt = txb_r[6];
                  cnt_nxt = cnt_r + 3'h1;
               end
            end
            // sequential read continues on host ack
            S_RACK: begin
               cnt_nxt = 3'h0;
               if (ack_ok_r) begin
                  txb_nxt = rd_byte;
                  oe_n_nxt = rd_byte[7];
                  wadr_nxt = wadr_r + 8'h1;
                  state_nxt = S_RDAT;
               end else begin
                  state_nxt = S_IDLE;
               end
            end
            default: ;
         endcase
      end
   end

   // Engine registers
   always_ff @(posedge CLK) begin
      if (RESET) begin
         state_r <= S_IDLE;
         cnt_r <= 3'h0;
         sh_r <= 8'h0;
         txb_r <= 8'h0;
         wadr_r <= 8'h0;
         dev_r <= 8'h0;
         sel_r <= 1'b0;
         rw_r <= 1'b0;
         ack_ok_r <= 1'b0;
         SDA_OE_N <= 1'b1;
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         txb_r <= txb_nxt;
         wadr_r <= wadr_nxt;
         dev_r <= dev_nxt;
         sel_r <= sel_nxt;
         rw_r <= rw_nxt;
         ack_ok_r <= ack_ok_nxt;
         SDA_OE_N <= oe_n_nxt;
         scl_q_r <= scl_s;
         sda_q_r <= sda_s;
      end
   end

   // Host write held until the port is free of firmware writes
   always_ff @(posedge CLK) begin
      if (RESET) begin
         pw_pend_r <= 1'b0;
         pw_sel_r <= 1'b0;
         pw_adr_r <= 8'h0;
         pw_dat_r <= 8'h0;
      end else if (pw_cap) begin
         pw_pend_r <= 1'b1;
         pw_sel_r <= sel_r;
         pw_adr_r <= wadr_r;
         pw_dat_r <= byte_in;
      end else if (~mw_wr) begin
         pw_pend_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   // ack only for owned address
   own_addr_a: assert property (@(posedge CLK) disable iff (RESET)
      state_r == S_DEV_ACK |-> dev_r[7:1] == ADDR_ID
         || dev_r[7:1] == ADDR_DIAG)
      else $error("ack for foreign address");
   // data moves only with clock low
   launch_edge_a: assert property (@(posedge CLK) disable iff (RESET)
      $changed(SDA_OE_N) && !start_c && !stop_c |-> !scl_s)
      else $error("data changed while clock high");
   // no host write to live area or locked ID
   protect_a: assert property (@(posedge CLK) disable iff (RESET)
      pw_cap |-> (sel_r ? !in_live : !ctrl_r[CTRL_WP_ID]))
      else $error("write into protected segment");
   // address steps after a written byte
   addr_step_a: assert property (@(posedge CLK) disable iff (RESET)
      pw_cap |=> wadr_r == 8'($past(wadr_r) + 8'h1))
      else $error("word address did not step");
   alarm_flag_a: assert property (@(posedge CLK) disable iff (RESET)
      out_high(mon_r[0], lim_r[0][LIM_HA]) |=> alm_r[NFLAG-1])
      else $error("alarm flag missing");
   loss_pin_a: assert property (@(posedge CLK) disable iff (RESET)
      ##1 RX_SIGNAL_LOST == !$past(sigok_s))
      else $error("loss output wrong");
   tx_off_a: assert property (@(posedge CLK) disable iff (RESET)
      TX_DISABLE [*4] |-> ##[0:TXDIS_BOUND] !TX_ON)
      else $error("transmitter not stopped");
   fault_pin_a: assert property (@(posedge CLK) disable iff (RESET)
      fault_s |=> TX_FAULT)
      else $error("fault not reported");
   present_a: assert property (@(posedge CLK) disable iff (RESET)
      ##1 !PRESENT_N)
      else $error("presence pin not low");

   diag_read_c: cover property (@(posedge CLK) disable iff (RESET)
      state_r == S_RDAT && sel_r);
   id_write_c: cover property (@(posedge CLK) disable iff (RESET)
      pw_cap && !sel_r);
   nack_end_c: cover property (@(posedge CLK) disable iff (RESET)
      state_r == S_RACK && scl_fall && !ack_ok_r);
endmodule

// ### tb/omms_host.sv
// Host controller model driving the two-wire management bus
`timescale 1ns/1ps
module omms_host (
   output logic scl,
   output logic sda_drv,
   input wire logic sda
);
   // Clock idles high and moves only inside frames
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // host makes clock; long low phase covers slave sync delay
   task automatic put_bit(input logic b);
      sda_drv = b;
      #200 scl = 1'b1;
      #100 scl = 0;
      #100;
   endtask
   // Sample just before the falling edge
   task automatic get_bit(output logic b);
      sda_drv = 1'b1;
      #200 scl = 1'b1;
      #90 b = sda;
      #10 scl = 1'b0;
      #100;
   endtask
   // data moves while clock high; edges kept off CLK edges
   task automatic start();
      #((60 - $time % 50) % 50);
      sda_drv = 1'b1;
      #200 scl = 1'b1;
      #200 sda_drv = 1'b0;
      #200 scl = 1'b0;
      #100;
   endtask
   task automatic stop();
      sda_drv = 1'b0;
      #200 scl = 1'b1;
      #200 sda_drv = 1'b1;
      #200;
   endtask
   task automatic send(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--) put_bit(d[i]);
      get_bit(ack);
   endtask
   task automatic recv(input logic last, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) get_bit(d[i]);
      put_bit(last);
   endtask
endmodule

// ### tb/test_omms_top.sv
// Self-checking bench for the management slave
`timescale 1ns/1ps
module test_omms_top
   import omms_pkg::*;
;
   logic CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, SCL;
   logic SDA_OUT, SDA_OE_N, TX_DISABLE, RX_SIGNAL_OK, LASER_FAULT;
   logic TX_ON, TX_FAULT, RX_SIGNAL_LOST, PRESENT_N, sda_drv, k;
   logic [11:0] PADDR;
   logic [31:0] PWDATA, PRDATA, res, r;
   logic [31:0] exp_q[$], msk_q[$];
   logic [7:0] d[3];
   logic [15:0] v;
   int n_fail, cmp_count, seed = 14461;
   event res_ev;
   // Open-drain data line with pull-up
   wire sda = sda_drv & (SDA_OE_N | SDA_OUT);
   omms_top u_omms_top (.CLK(CLK), .RESET(RESET), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ),
      .SCL(SCL), .SDA_IN(sda), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N),
      .TX_DISABLE(TX_DISABLE), .RX_SIGNAL_OK(RX_SIGNAL_OK),
      .LASER_FAULT(LASER_FAULT), .TX_ON(TX_ON), .TX_FAULT(TX_FAULT),
      .RX_SIGNAL_LOST(RX_SIGNAL_LOST), .PRESENT_N(PRESENT_N));
   omms_host u_omms_host (.scl(SCL), .sda_drv(sda_drv), .sda(sda));
   ////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic timeout();
      n_fail++;
      $display("unexpected at %0t: wait ran out", $time);
      end_of_test();
   endtask
   // Note the expectation, then post the result
   task automatic chk(input logic [31:0] e, m, g);
      exp_q.push_back(e);
      msk_q.push_back(m);
      res = g;
      ->res_ev;
   endtask
   // Oldest note against each posted result
   always @(res_ev) begin
      cmp_count++;
      if (((res ^ exp_q[0]) & msk_q[0]) !== 32'h0) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, res, exp_q[0]);
      end
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
   end
   // APB transfer, read data left in r
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] wd, output logic e);
      int n = 0;
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= wd;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 20);
      if (n >= 20) timeout();
      r = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   // Device address and word address
   task automatic frame(input logic [6:0] dv, input logic [7:0] a);
      u_omms_host.start();
      u_omms_host.send({dv, 1'b0}, k);
      chk(0, 1, k);
      u_omms_host.send(a, k);
      chk(0, 1, k);
   endtask
   task automatic ser_rd(input logic [6:0] dv, input logic [7:0] a,
                         input logic [7:0] ex[$], input logic [7:0] m);
      logic [7:0] b;
      frame(dv, a);
      u_omms_host.start();
      u_omms_host.send({dv, 1'b1}, k);
      chk(0, 1, k);
      foreach (ex[i]) begin
         u_omms_host.recv(i == ex.size() - 1, b);
         chk(ex[i], m, b);
      end
      u_omms_host.stop();
   endtask
   task automatic ser_wr(input logic [6:0] dv, input logic [7:0] a, wd);
      frame(dv, a);
      u_omms_host.send(wd, k);
      chk(0, 1, k);
      u_omms_host.stop();
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Clock and overall time limit
   initial begin
      CLK = 1'b0;
      forever #25 CLK = ~CLK;
   end
   initial begin
      #5000000;
      timeout();
   end
   // Main sequence
   initial begin
      {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
      {TX_DISABLE, RX_SIGNAL_OK, LASER_FAULT} = 3'h6;
      RESET = 1'b1;
      repeat (10) @(posedge CLK);
      RESET <= 1'b0;
      repeat (4) @(posedge CLK);
      repeat (6) begin
         {TX_DISABLE, RX_SIGNAL_OK, LASER_FAULT} <= 3'($random(seed));
         repeat (201) @(posedge CLK);
         v = {~TX_DISABLE, LASER_FAULT, ~RX_SIGNAL_OK, 1'b0};
         r = {TX_ON, TX_FAULT, RX_SIGNAL_LOST, PRESENT_N};
         chk(v, 32'hf, r);
      end
      $display("pin test done");
      apb(0, REG_CTRL, 0, k);
      chk(CTRL_RST, 32'h7, r);
      apb(0, 12'h020, 0, k);
      chk({r[30:0], k}, 32'hffffffff, 1);
      foreach (d[i]) begin
         d[i] = 8'($random(seed));
         apb(1, REG_MEMWR, {16'h0, 8'(8'hfe + i), d[i]}, k);
      end
      ser_rd(ADDR_ID, 8'hfe, {d[0], d[1], d[2]}, 8'hff);
      $display("id memory test done");
      apb(1, REG_MEMWR, {16'h0, ID_DIAG_TYPE, 8'h00}, k);
      apb(1, REG_MEMWR, {16'h0, 8'h10, d[0]}, k);
      apb(1, REG_MEMWR, {16'h1, 8'h10, d[1]}, k);
      ser_rd(ADDR_ID, ID_DIAG_TYPE, {CAL_INT_MASK}, 8'hff);
      ser_wr(ADDR_ID, 8'h10, ~d[0]);
      ser_rd(ADDR_ID, 8'h10, {d[0]}, 8'hff);
      ser_rd(ADDR_DIAG, 8'h10, {d[1]}, 8'hff);
      apb(1, REG_CTRL, 0, k);
      ser_wr(ADDR_ID, 8'h10, ~d[0]);
      ser_rd(ADDR_ID, 8'h10, {~d[0]}, 8'hff);
      $display("protect test done");
      v = {1'b1, 15'($random(seed))};
      apb(1, REG_LIM_BASE, v - 16'h1, k);
      apb(1, REG_LIM_BASE + 12'h4, 0, k);
      apb(1, REG_LIM_BASE + 12'h8, 32'hffff, k);
      apb(1, REG_LIM_BASE + 12'hc, 0, k);
      apb(1, REG_MASK, 1, k);
      apb(1, REG_MON_BASE, v, k);
      repeat (4) @(posedge CLK);
      chk(1, 1, IRQ);
      ser_rd(ADDR_DIAG, DG_MON_LO, {v[15:8], v[7:0]}, 8'hff);
      ser_rd(ADDR_DIAG, DG_ALM0, {8'h80}, 8'hc0);
      apb(0, REG_STATUS, 0, k);
      chk(5, 5, r);
      apb(0, REG_STATUS, 0, k);
      chk(0, 1, r);
      repeat (2) @(posedge CLK);
      chk(0, 1, IRQ);
      $display("monitor test done");
      u_omms_host.start();
      u_omms_host.send({7'h52, 1'b0}, k);
      chk(1, 1, k);
      u_omms_host.stop();
      $display("foreign address test done");
      end_of_test();
   end
endmodule
